// File: hw/cardbus_io_window_reported_pin_value_regs.sv
// CardBus bridge I/O window, interrupt line and interrupt pin configuration registers
`timescale 1ns/100ps
`default_nettype none

module cardbus_io_window_reported_pin_value_regs (
	input  wire logic                       core_clk,
	input  wire logic                       rstn,
	input  wire logic [2:0]                 func_num,
	input  wire cb_io_regs_pkg::cfg_req_t   cfg_req,
	output var  cb_io_regs_pkg::cfg_resp_t  cfg_resp,
	input  wire cb_io_regs_pkg::io_req_t    io_req,
	output var  cb_io_regs_pkg::io_resp_t   io_resp,
	output logic                            tie_a_b_irq_bit,
	output logic                            tie_every_irq_bit,
	output logic [7:0]                      reported_pin_value
);
	import cb_io_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [5:0] dw_of(input logic [7:0] ofs);
		dw_of = ofs[7:2];
	endfunction

	// Byte-lane merge, then force read-only bits back to zero
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = m & wmask;
	endfunction

	function automatic logic [7:0] pin_code(input logic [2:0] fn, input logic ab, input logic all);
		logic [7:0] p;
		p = PIN_NONE;
		if (fn == FUNC_0) begin
			p = PIN_A;
		end else if (fn == FUNC_1) begin
			p = (ab || all) ? PIN_A : PIN_B;
		end else if (fn == FUNC_2) begin
			p = all ? PIN_A : PIN_C;
		end
		pin_code = p;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [31:0] io_base  [WINDOWS];
	logic [31:0] io_limit [WINDOWS];
	logic [7:0]  irq_routing_scratch;
	logic        tie_a_b;
	logic        tie_every;

	wire         wr_en      = cfg_req.valid && cfg_req.write;
	wire         wr_irq     = wr_en && (cfg_req.dw_addr == dw_of(OFS_IRQ_WORD));
	wire         wr_sysctl  = wr_en && (cfg_req.dw_addr == dw_of(OFS_SYS_CTRL));
	wire [1:0]   line_lane  = OFS_IRQ_LINE[1:0];
	wire [31:0]  sys_word   = {2'h0, tie_a_b, tie_every, 28'h0};
	wire [31:0]  next_sys   = merge(sys_word, cfg_req.wdata, cfg_req.byte_en, 32'hFFFF_FFFF);
	wire [7:0]   next_pin   = pin_code(func_num, tie_a_b, tie_every);

	logic [WINDOWS-1:0] win_en;
	logic [WINDOWS-1:0] win_hit;

	genvar g;
	generate
		for (g = 0; g < WINDOWS; g++) begin : g_win
			localparam logic [7:0] BASE_OFS  = OFS_IO0_BASE + 8'(g) * WINDOW_STRIDE;
			localparam logic [7:0] LIMIT_OFS = OFS_IO0_LIMIT + 8'(g) * WINDOW_STRIDE;
			wire wr_base  = wr_en && (cfg_req.dw_addr == dw_of(BASE_OFS));
			wire wr_limit = wr_en && (cfg_req.dw_addr == dw_of(LIMIT_OFS));
			wire [15:0] top = {io_limit[g][OFFS_MSB:2], LIMIT_LOW_ONES};

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					io_base[g]  <= WINDOW_RST;
					io_limit[g] <= WINDOW_RST;
				end else begin
					if (wr_base) begin
						io_base[g] <= merge(io_base[g], cfg_req.wdata, cfg_req.byte_en, BASE_WMASK);
					end
					if (wr_limit) begin
						io_limit[g] <= merge(io_limit[g], cfg_req.wdata, cfg_req.byte_en, LIMIT_WMASK);
					end
				end
			end

			assign win_en[g]  = (io_base[g] != WINDOW_RST) || (io_limit[g] != WINDOW_RST);
			assign win_hit[g] = win_en[g]
				&& (io_req.addr[PAGE_MSB:PAGE_LSB] == io_base[g][PAGE_MSB:PAGE_LSB])
				&& (io_req.addr[OFFS_MSB:0] >= io_base[g][OFFS_MSB:0])
				&& (io_req.addr[OFFS_MSB:0] <= top);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt line, tie bits

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			irq_routing_scratch <= IRQ_LINE_RST;
			tie_a_b             <= 1'b0;
			tie_every           <= 1'b0;
		end else begin
			if (wr_irq && cfg_req.byte_en[line_lane]) begin
				irq_routing_scratch <= cfg_req.wdata[8*line_lane +: 8];
			end
			// Software must have put terminal three into serialized mode first
			if (wr_sysctl) begin
				tie_a_b   <= next_sys[TIE_A_B_POS];
				tie_every <= next_sys[TIE_EVERY_POS];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration read path

	logic [31:0] rd_word;

	always_comb begin
		if (cfg_req.dw_addr == dw_of(OFS_IO0_BASE)) begin
			rd_word = io_base[0];
		end else if (cfg_req.dw_addr == dw_of(OFS_IO0_LIMIT)) begin
			rd_word = io_limit[0];
		end else if (cfg_req.dw_addr == dw_of(OFS_IO1_BASE)) begin
			rd_word = io_base[1];
		end else if (cfg_req.dw_addr == dw_of(OFS_IO1_LIMIT)) begin
			rd_word = io_limit[1];
		end else if (cfg_req.dw_addr == dw_of(OFS_IRQ_WORD)) begin
			rd_word = {16'h0, next_pin, irq_routing_scratch};
		end else if (cfg_req.dw_addr == dw_of(OFS_SYS_CTRL)) begin
			rd_word = sys_word;
		end else begin
			rd_word = 32'h0000_0000;
		end
	end

	// One-cycle answer; reads see the value before a same-cycle write
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cfg_resp <= '0;
		end else begin
			cfg_resp.ack   <= cfg_req.valid;
			cfg_resp.rdata <= (cfg_req.valid && !cfg_req.write) ? rd_word : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Window decode for both directions

	wire any_hit = |win_hit;
	wire hit_sel = win_hit[1] && !win_hit[0];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			io_resp <= '0;
		end else begin
			io_resp.valid  <= io_req.valid;
			io_resp.hit    <= io_req.valid && any_hit;
			io_resp.window <= io_req.valid && hit_sel;
			io_resp.claim  <= io_req.valid && !io_req.from_cardbus && any_hit;
			io_resp.to_pci <= io_req.valid && io_req.from_cardbus && !any_hit;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tie_a_b_irq_bit    <= 1'b0;
			tie_every_irq_bit  <= 1'b0;
			reported_pin_value <= PIN_A;
		end else begin
			tie_a_b_irq_bit    <= tie_a_b;
			tie_every_irq_bit  <= tie_every;
			reported_pin_value <= next_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_base0_write;
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO0_BASE) && cfg_req.byte_en[0];
	endsequence

	sequence s_base0_readback;
		##1 (io_base[0][1:0] == 2'h0) ##0 (io_base[0][7:2] == $past(cfg_req.wdata[7:2]));
	endsequence

	property p_base_write;
		@(posedge core_clk) disable iff (!rstn)
		s_base0_write |-> s_base0_readback;
	endproperty
	a_base_write: assert property (p_base_write) else $error("base write not stored as masked");

	property p_limit_ro;
		@(posedge core_clk) disable iff (!rstn)
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO1_LIMIT)
		|-> ##1 (io_limit[1][31:16] == 16'h0 && io_limit[1][1:0] == 2'h0);
	endproperty
	a_limit_ro: assert property (p_limit_ro) else $error("limit read-only bits changed");

	property p_line_reset;
		@(posedge core_clk) $past(!rstn) && rstn |-> irq_routing_scratch == IRQ_LINE_RST;
	endproperty
	a_line_reset: assert property (p_line_reset) else $error("interrupt line not FFh after reset");

	property p_disabled_quiet;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && win_en == '0 |=> io_resp.valid && !io_resp.hit && !io_resp.claim;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled window matched");

	property p_top_dword;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && win_en[0] && io_base[0][15:0] <= {io_limit[0][15:2], 2'h3}
		&& io_req.addr == {io_base[0][31:16], io_limit[0][15:2], 2'h3} |=> io_resp.hit;
	endproperty
	a_top_dword: assert property (p_top_dword) else $error("last doubleword of window missed");

	property p_cardbus_route;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && io_req.from_cardbus |=> io_resp.to_pci == !io_resp.hit && !io_resp.claim;
	endproperty
	a_cardbus_route: assert property (p_cardbus_route) else $error("CardBus routing wrong");

	property p_pin_all;
		@(posedge core_clk) disable iff (!rstn)
		tie_every && func_num <= FUNC_2 && $stable(func_num) && $stable(tie_every) |=> reported_pin_value == PIN_A;
	endproperty
	a_pin_all: assert property (p_pin_all) else $error("all-tie pin code wrong");

	property p_pin_ab;
		@(posedge core_clk) disable iff (!rstn)
		tie_a_b && !tie_every && func_num == FUNC_2 |=> reported_pin_value == PIN_C;
	endproperty
	a_pin_ab: assert property (p_pin_ab) else $error("A-B tie pin code wrong");

	property p_pin_plain;
		@(posedge core_clk) disable iff (!rstn)
		!tie_a_b && !tie_every && func_num == FUNC_1 ##1 cfg_req.valid && !cfg_req.write
		&& cfg_req.dw_addr == dw_of(OFS_IRQ_PIN) && !tie_a_b && !tie_every && func_num == FUNC_1
		|=> cfg_resp.ack && cfg_resp.rdata[PIN_LSB +: 8] == PIN_B;
	endproperty
	a_pin_plain: assert property (p_pin_plain) else $error("untied pin code wrong");

	sequence s_irq_write;
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IRQ_WORD);
	endsequence

	sequence s_sys_write;
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_SYS_CTRL);
	endsequence

	property p_limit_write;
		@(posedge core_clk) disable iff (!rstn)
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO0_LIMIT) && cfg_req.byte_en[1]
		|=> io_limit[0][OFFS_MSB:8] == $past(cfg_req.wdata[OFFS_MSB:8]);
	endproperty
	a_limit_write: assert property (p_limit_write) else $error("limit window top not stored");

	property p_base_page_write;
		@(posedge core_clk) disable iff (!rstn)
		cfg_req.valid && cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO1_BASE) && cfg_req.byte_en[3]
		|=> io_base[1][PAGE_MSB:24] == $past(cfg_req.wdata[PAGE_MSB:24]);
	endproperty
	a_base_page_write: assert property (p_base_page_write) else $error("base page not stored");

	property p_line_write;
		@(posedge core_clk) disable iff (!rstn)
		s_irq_write ##0 cfg_req.byte_en[0] |=> irq_routing_scratch == $past(cfg_req.wdata[7:0]);
	endproperty
	a_line_write: assert property (p_line_write) else $error("interrupt line write lost");

	property p_line_keep;
		@(posedge core_clk) disable iff (!rstn)
		s_irq_write ##0 !cfg_req.byte_en[0] |=> $stable(irq_routing_scratch);
	endproperty
	a_line_keep: assert property (p_line_keep) else $error("interrupt line changed without lane");

	property p_tie_write;
		@(posedge core_clk) disable iff (!rstn)
		s_sys_write ##0 cfg_req.byte_en[3] |=> tie_a_b == $past(cfg_req.wdata[TIE_A_B_POS])
		&& tie_every == $past(cfg_req.wdata[TIE_EVERY_POS]);
	endproperty
	a_tie_write: assert property (p_tie_write) else $error("tie bits not stored");

	property p_pin_func0;
		@(posedge core_clk) disable iff (!rstn)
		func_num == FUNC_0 |=> reported_pin_value == PIN_A;
	endproperty
	a_pin_func0: assert property (p_pin_func0) else $error("function 0 pin code wrong");

	property p_pin_other;
		@(posedge core_clk) disable iff (!rstn)
		func_num > FUNC_2 |=> reported_pin_value == PIN_NONE;
	endproperty
	a_pin_other: assert property (p_pin_other) else $error("unused function pin code wrong");

	property p_pci_claim;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && !io_req.from_cardbus |=> io_resp.claim == io_resp.hit && !io_resp.to_pci;
	endproperty
	a_pci_claim: assert property (p_pci_claim) else $error("PCI claim wrong");

	property p_page_miss;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && io_req.addr[PAGE_MSB:PAGE_LSB] != io_base[0][PAGE_MSB:PAGE_LSB]
		&& io_req.addr[PAGE_MSB:PAGE_LSB] != io_base[1][PAGE_MSB:PAGE_LSB] |=> !io_resp.hit;
	endproperty
	a_page_miss: assert property (p_page_miss) else $error("hit outside base page");

	property p_window_pick;
		@(posedge core_clk) disable iff (!rstn)
		io_req.valid && win_en[0] && io_req.addr == io_base[0]
		&& io_base[0][OFFS_MSB:0] <= {io_limit[0][OFFS_MSB:2], LIMIT_LOW_ONES} |=> io_resp.hit && !io_resp.window;
	endproperty
	a_window_pick: assert property (p_window_pick) else $error("window bottom missed");

	property p_base_read;
		@(posedge core_clk) disable iff (!rstn)
		cfg_req.valid && !cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO0_BASE)
		|=> cfg_resp.ack && cfg_resp.rdata == $past(io_base[0]) && cfg_resp.rdata[1:0] == 2'h0;
	endproperty
	a_base_read: assert property (p_base_read) else $error("base read wrong");

	property p_limit_read;
		@(posedge core_clk) disable iff (!rstn)
		cfg_req.valid && !cfg_req.write && cfg_req.dw_addr == dw_of(OFS_IO1_LIMIT)
		|=> cfg_resp.ack && cfg_resp.rdata[PAGE_MSB:PAGE_LSB] == 16'h0 && cfg_resp.rdata[1:0] == 2'h0;
	endproperty
	a_limit_read: assert property (p_limit_read) else $error("limit read-only bits not zero");

endmodule // cardbus_io_window_reported_pin_value_regs

`default_nettype wire

// File: hw/cb_io_regs_pkg.sv
// Constants and carrier types for the CardBus I/O window and interrupt pin registers
package cb_io_regs_pkg;

	// Configuration offsets (byte addresses)
	localparam logic [7:0] OFS_IO0_BASE     = 8'h2C;
	localparam logic [7:0] OFS_IO0_LIMIT    = 8'h30;
	localparam logic [7:0] OFS_IO1_BASE     = 8'h34;
	localparam logic [7:0] OFS_IO1_LIMIT    = 8'h38;
	localparam logic [7:0] OFS_IRQ_WORD     = 8'h3C;
	localparam logic [7:0] OFS_IRQ_LINE     = 8'h3C;
	localparam logic [7:0] OFS_IRQ_PIN      = 8'h3D;
	localparam logic [7:0] OFS_SYS_CTRL     = 8'h80;
	localparam int unsigned WINDOWS         = 2;
	localparam logic [7:0] WINDOW_STRIDE    = 8'h08;

	// Field layouts
	localparam logic [31:0] BASE_WMASK      = 32'hFFFF_FFFC;
	localparam logic [31:0] LIMIT_WMASK     = 32'h0000_FFFC;
	localparam logic [1:0]  LIMIT_LOW_ONES  = 2'h3;
	localparam int unsigned PAGE_MSB        = 31;
	localparam int unsigned PAGE_LSB        = 16;
	localparam int unsigned OFFS_MSB        = 15;
	localparam int unsigned PIN_LSB         = 8;
	localparam int unsigned TIE_A_B_POS     = 29;
	localparam int unsigned TIE_EVERY_POS   = 28;

	// Reset values
	localparam logic [31:0] WINDOW_RST      = 32'h0000_0000;
	localparam logic [7:0]  IRQ_LINE_RST    = 8'hFF;

	// Reported pin codes
	localparam logic [7:0]  PIN_NONE        = 8'h00;
	localparam logic [7:0]  PIN_A           = 8'h01;
	localparam logic [7:0]  PIN_B           = 8'h02;
	localparam logic [7:0]  PIN_C           = 8'h03;
	localparam logic [2:0]  FUNC_0          = 3'h0;
	localparam logic [2:0]  FUNC_1          = 3'h1;
	localparam logic [2:0]  FUNC_2          = 3'h2;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [5:0]  dw_addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} cfg_resp_t;

	typedef struct packed {
		logic        valid;
		logic        from_cardbus;
		logic [31:0] addr;
	} io_req_t;

	typedef struct packed {
		logic        valid;
		logic        hit;
		logic        window;
		logic        claim;
		logic        to_pci;
	} io_resp_t;

endpackage

// File: test/cfg_io_host.sv
// Host model issuing configuration and I/O cycles to the register block
`timescale 1ns/100ps
`default_nettype none

module cfg_io_host (
	input  wire logic                       core_clk,
	output var  cb_io_regs_pkg::cfg_req_t   cfg_req,
	input  wire cb_io_regs_pkg::cfg_resp_t  cfg_resp,
	output var  cb_io_regs_pkg::io_req_t    io_req,
	input  wire cb_io_regs_pkg::io_resp_t   io_resp
);
	import cb_io_regs_pkg::*;

	initial begin
		cfg_req = '0;
		io_req = '0;
	end

	////////////////////////////////////////
	// One-cycle strobes; idle fields flipped so stale data never looks valid
	task automatic cfg(input logic wr, input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk);
		#1;
		cfg_req = '{1'b1, wr, ofs[7:2], be, wd};
		@(posedge core_clk);
		#1;
		cfg_req = '{1'b0, ~wr, ~ofs[7:2], ~be, ~wd};
		rd = (cfg_resp.ack === 1'b1) ? cfg_resp.rdata : 'x;
	endtask

	task automatic io(input logic cb, input logic [31:0] x, output io_resp_t r);
		@(posedge core_clk);
		#1;
		io_req = '{1'b1, cb, x};
		@(posedge core_clk);
		#1;
		io_req = '{1'b0, ~cb, ~x};
		r = (io_resp.valid === 1'b1) ? io_resp : 'x;
	endtask
endmodule // cfg_io_host

`default_nettype wire

// File: test/cardbus_io_window_reported_pin_value_regs_tb.sv
// Self-checking bench for the I/O window and interrupt pin registers
`timescale 1ns/100ps
`default_nettype none

module cardbus_io_window_reported_pin_value_regs_tb;
	import cb_io_regs_pkg::*;

	logic              core_clk;
	logic              rstn;
	logic [2:0]        func_num;
	cfg_req_t          cfg_req;
	cfg_resp_t         cfg_resp;
	io_req_t           io_req;
	io_resp_t          io_resp;
	io_resp_t          r;
	logic              tie_a_b_irq_bit;
	logic              tie_every_irq_bit;
	logic [7:0]        reported_pin_value;
	logic [7:0]        j;
	logic [7:0]        ofs;
	logic [31:0]       rd;
	logic [31:0]       w;
	logic [31:0]       bas [2];
	logic [31:0]       lim [2];
	int                n_mismatch;
	int                checked;
	int                seed;

	cardbus_io_window_reported_pin_value_regs dut_u (.core_clk(core_clk), .rstn(rstn), .func_num(func_num),
		.cfg_req(cfg_req), .cfg_resp(cfg_resp), .io_req(io_req), .io_resp(io_resp),
		.tie_a_b_irq_bit(tie_a_b_irq_bit), .tie_every_irq_bit(tie_every_irq_bit),
		.reported_pin_value(reported_pin_value));
	cfg_io_host host_u (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_resp(cfg_resp), .io_req(io_req),
		.io_resp(io_resp));

	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [31:0] merge(input logic [31:0] old, wd, m, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			if (be[i])
				old[8*i+:8] = wd[8*i+:8];
		return old & m;
	endfunction

	function automatic logic hit_of(input int k, input logic [31:0] x);
		return (bas[k] | lim[k]) != 0 && x[31:16] == bas[k][31:16] && x[15:0] >= bas[k][15:0]
			&& x[15:0] <= {lim[k][15:2], 2'b11};
	endfunction

	function automatic logic [7:0] pin_of(input logic [2:0] f, input logic ab, all);
		if (f > 3'h2)
			return 8'h00;
		if (all || f == 3'h0)
			return 8'h01;
		if (f == 3'h1)
			return ab ? 8'h01 : 8'h02;
		return 8'h03;
	endfunction

	// Window index only meaningful on a hit
	task automatic io_chk(input logic cb, input logic [31:0] x);
		logic h0;
		logic h;
		h0 = hit_of(0, x);
		h = h0 | hit_of(1, x);
		host_u.io(cb, x, r);
		chk(32'({r.hit, r.claim, r.to_pci}), 32'({h, !cb && h, cb && !h}));
		if (h)
			chk(32'(r.window), 32'(!h0));
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host_u.cfg(1'b0, a, 4'hF, $random(seed), rd);
		chk(rd, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		host_u.cfg(1'b1, a, be, d, rd);
		chk(rd, 32'h0);
	endtask

	////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Run needs under two thousand cycles
	initial begin
		#80000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		seed = 32'h186E;
		rstn = 1'b0;
		func_num = 3'h0;
		bas = '{default: '0};
		lim = '{default: '0};
		repeat (3) @(posedge core_clk);
		#1 rstn = 1'b1;
		for (int k = 0; k < 4; k++)
			rd_chk(OFS_IO0_BASE + 8'(4 * k), 32'h0);
		rd_chk(8'hF0, 32'h0);
		host_u.cfg(1'b0, OFS_IRQ_WORD, 4'hF, 32'h0, rd);
		chk({16'h0, rd[15:0]}, 32'h01FF);
		chk({24'h0, reported_pin_value}, 32'h01);
		io_chk(1'b0, 32'h0);
		io_chk(1'b1, 32'h0);
		repeat (60) begin
			w = $random(seed);
			j = 8'($random(seed));
			ofs = OFS_IO0_BASE + {4'h0, j[1:0], 2'b00};
			if (j[0])
				lim[j[1]] = merge(lim[j[1]], w, LIMIT_WMASK, j[7:4]);
			else
				bas[j[1]] = merge(bas[j[1]], w, BASE_WMASK, j[7:4]);
			wr(ofs, j[7:4], w);
			rd_chk(ofs, j[0] ? lim[j[1]] : bas[j[1]]);
			for (int k = 0; k < 2; k++) begin
				io_chk(j[2], bas[k]);
				io_chk(j[2], {bas[k][31:16], lim[k][15:2], 2'b11});
				io_chk(j[3], {bas[k][31:16], lim[k][15:2], 2'b11} + 32'h1);
				io_chk(j[3], bas[k] - 32'h1);
				io_chk(j[2], {~bas[k][31:16], bas[k][15:0]});
			end
			io_chk(j[2], w);
		end
		wr(OFS_IO0_BASE, 4'hF, 32'h0);
		bas[0] = 32'h0;
		wr(OFS_IO0_LIMIT, 4'hF, 32'hFFFF_0013);
		lim[0] = 32'h10;
		io_chk(1'b0, 32'h0);
		io_chk(1'b0, 32'h13);
		io_chk(1'b1, 32'h14);
		wr(OFS_IO0_LIMIT, 4'hF, 32'h0);
		lim[0] = 32'h0;
		io_chk(1'b0, 32'h0);
		for (int t = 0; t < 16; t++) begin
			w = $random(seed);
			func_num = {1'b0, t[1:0]};
			// Terminal three taken as serialized before any tie is set
			wr(OFS_SYS_CTRL, 4'hF, {w[31:30], t[3], t[2], w[27:0]});
			rd_chk(OFS_SYS_CTRL, {2'b00, t[3], t[2], 28'h0});
			wr(OFS_IRQ_WORD, 4'h3, w);
			wr(OFS_IRQ_WORD, 4'hE, ~w);
			host_u.cfg(1'b0, OFS_IRQ_WORD, 4'hF, 32'h0, rd);
			chk({16'h0, rd[15:0]}, {16'h0, pin_of(func_num, t[3], t[2]), w[7:0]});
			chk({22'h0, tie_a_b_irq_bit, tie_every_irq_bit, reported_pin_value},
				{22'h0, t[3], t[2], pin_of(func_num, t[3], t[2])});
		end
		print_verdict();
	end
endmodule // cardbus_io_window_reported_pin_value_regs_tb

`default_nettype wire
